/* File: common/cce_defines.svh */
// Opcode, cycle-count and field-position constants for the call/clear/complement execution block.
`ifndef CCE_DEFINES_SVH
`define CCE_DEFINES_SVH
`define CCE_OPC_CALL_DIRECT 8'hD6
`define CCE_OPC_CALL_PAIR 8'hD4
`define CCE_OPC_CARRY_INVERT 8'hEF
`define CCE_OPC_ZERO_FILL_REG 8'hB0
`define CCE_OPC_ZERO_FILL_PTR 8'hB1
`define CCE_OPC_INVERT_REG 8'h60
`define CCE_OPC_INVERT_PTR 8'h61
`define CCE_OPC_EXIT 8'hAF
`define CCE_CYC_CALL 5'h14
`define CCE_CYC_SHORT 5'h06
`define CCE_CYC_EXIT 5'h0E
`define CCE_SP_STEP 16'h0002
`define CCE_WORK_NIBBLE 4'hE
`define CCE_WORK_BASE 4'h0
`define CCE_FLAG_C 7
`define CCE_FLAG_Z 6
`define CCE_FLAG_S 5
`define CCE_FLAG_V 4
`define CCE_SIGN_BIT 7
`endif

/* File: common/cce_pkg.sv */
// Types shared by the call/clear/complement execution block.
package cce_pkg;
  typedef enum logic [3:0] {
    CCE_IDLE = 4'h0,
    CCE_FETCH_PTR = 4'h1,
    CCE_READ_OPND = 4'h2,
    CCE_WRITE_OPND = 4'h3,
    CCE_PUSH_HI = 4'h4,
    CCE_PUSH_LO = 4'h5,
    CCE_POP_HI = 4'h6,
    CCE_POP_LO = 4'h7,
    CCE_FINISH = 4'h8
  } cce_state_t;
  typedef enum logic [2:0] {
    CCE_K_NONE = 3'h0,
    CCE_K_CALL = 3'h1,
    CCE_K_CARRY = 3'h2,
    CCE_K_ZERO = 3'h3,
    CCE_K_INVERT = 3'h4,
    CCE_K_EXIT = 3'h5
  } cce_kind_t;
endpackage

/* File: hw/cce_cycle_timer.sv */
// Down-counter that stretches each instruction to its documented cycle count.
module cce_cycle_timer #(
  parameter int WIDTH = 5
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic load,
  input wire logic [WIDTH-1:0] count,
  output logic done
);
  logic [WIDTH-1:0] remaining;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      remaining <= '0;
    end else if (load) begin
      remaining <= count - WIDTH'(1);
    end else if (remaining != '0) begin
      remaining <= remaining - WIDTH'(1);
    end
  end

  assign done = (remaining == '0) && !load;
endmodule

/* File: hw/cce_exec.sv */
// Execution unit for procedure call/exit, carry invert, zero fill and bitwise invert.
`include "cce_defines.svh"

// Contract
// - Call: lower stack pointer by 2, push instruction pointer, then load destination.
// - D6 calls direct address, D4 calls via register pair; 20 cycles, flags kept.
// - Saved instruction pointer is the address following the call instruction.
// - Procedure exit pops the stack top into the instruction pointer.
// - EF inverts carry in 6 cycles; other flags unchanged.
// - B0/B1 write zero to destination in 6 cycles; flags unchanged.
// - 60/61 replace destination with its bitwise inverse in 6 cycles.
// - Inversion sets Z on zero, S from bit 7, clears V, keeps C/H/D.
// - Operand upper nibble E selects working register from the lower nibble.
module cce_exec (
  input wire logic CORE_CLK,
  input wire logic RESET,
  input wire logic START,
  input wire logic [7:0] OPCODE,
  input wire logic [7:0] OPERAND,
  input wire logic [15:0] DEST_ADDR,
  input wire logic [15:0] NEXT_IP,
  input wire logic [15:0] STACK_PTR_IN,
  input wire logic [7:0] FLAGS_IN,
  input wire logic [3:0] WORK_PTR,
  output logic BUSY,
  output logic DONE,
  output logic ILLEGAL,
  output logic REG_RD,
  output logic REG_WR,
  output logic [7:0] REG_ADDR,
  output logic [7:0] REG_WDATA,
  input wire logic [7:0] REG_RDATA,
  output logic STK_RD,
  output logic STK_WR,
  output logic [15:0] STK_ADDR,
  output logic [7:0] STK_WDATA,
  input wire logic [7:0] STK_RDATA,
  output logic IP_LOAD,
  output logic [15:0] IP_VALUE,
  output logic SP_LOAD,
  output logic [15:0] SP_VALUE,
  output logic FLAGS_LOAD,
  output logic [7:0] FLAGS_VALUE
);
  cce_pkg::cce_state_t state;
  cce_pkg::cce_state_t next_state;
  cce_pkg::cce_kind_t kind;
  logic indirect;
  logic [7:0] opnd;
  logic [7:0] target;
  logic [15:0] ret_addr;
  logic [15:0] dest;
  logic [15:0] sp;
  logic [7:0] pop_hi;
  logic timer_done;

  // Expands a short working-register operand; other values name a register directly.
  function automatic logic [7:0] resolve_reg(input logic [7:0] code, input logic [3:0] wp);
    resolve_reg = (code[7:4] == `CCE_WORK_NIBBLE) ? {wp, code[3:0]} : code;
  endfunction

  wire is_call_direct = (OPCODE == `CCE_OPC_CALL_DIRECT);
  wire is_call_pair = (OPCODE == `CCE_OPC_CALL_PAIR);
  wire is_carry = (OPCODE == `CCE_OPC_CARRY_INVERT);
  wire is_zero = (OPCODE == `CCE_OPC_ZERO_FILL_REG) || (OPCODE == `CCE_OPC_ZERO_FILL_PTR);
  wire is_invert = (OPCODE == `CCE_OPC_INVERT_REG) || (OPCODE == `CCE_OPC_INVERT_PTR);
  wire is_exit = (OPCODE == `CCE_OPC_EXIT);
  wire opc_ptr = OPCODE[0];
  wire accept = START && (state == cce_pkg::CCE_IDLE);
  wire known = is_call_direct || is_call_pair || is_carry || is_zero || is_invert || is_exit;
  wire [4:0] cycles = (is_call_direct || is_call_pair) ? `CCE_CYC_CALL :
    is_exit ? `CCE_CYC_EXIT : `CCE_CYC_SHORT;
  wire [7:0] inverted = ~REG_RDATA;
  wire [7:0] resolved = resolve_reg(OPERAND, WORK_PTR);
  wire [15:0] sp_lowered = STACK_PTR_IN - `CCE_SP_STEP;
  wire [7:0] pair_base = {target[7:1], 1'b0};

  cce_cycle_timer #(.WIDTH(5)) u_timer (
    .clk(CORE_CLK),
    .rst(RESET),
    .load(accept && known),
    .count(cycles),
    .done(timer_done)
  );

  always_comb begin
    next_state = state;
    unique case (state)
      cce_pkg::CCE_IDLE: begin
        if (accept && known) begin
          if (is_call_pair || ((is_zero || is_invert) && opc_ptr)) begin
            next_state = cce_pkg::CCE_FETCH_PTR;
          end else if (is_call_direct) begin
            next_state = cce_pkg::CCE_PUSH_HI;
          end else if (is_invert) begin
            next_state = cce_pkg::CCE_READ_OPND;
          end else if (is_zero) begin
            next_state = cce_pkg::CCE_WRITE_OPND;
          end else if (is_exit) begin
            next_state = cce_pkg::CCE_POP_HI;
          end else begin
            next_state = cce_pkg::CCE_FINISH;
          end
        end
      end
      cce_pkg::CCE_FETCH_PTR: begin
        if (kind == cce_pkg::CCE_K_CALL) begin
          next_state = indirect ? cce_pkg::CCE_PUSH_HI : cce_pkg::CCE_FETCH_PTR;
        end else begin
          next_state = (kind == cce_pkg::CCE_K_INVERT) ? cce_pkg::CCE_READ_OPND : cce_pkg::CCE_WRITE_OPND;
        end
      end
      cce_pkg::CCE_READ_OPND: next_state = cce_pkg::CCE_WRITE_OPND;
      cce_pkg::CCE_WRITE_OPND: next_state = cce_pkg::CCE_FINISH;
      cce_pkg::CCE_PUSH_HI: next_state = cce_pkg::CCE_PUSH_LO;
      cce_pkg::CCE_PUSH_LO: next_state = cce_pkg::CCE_FINISH;
      cce_pkg::CCE_POP_HI: next_state = cce_pkg::CCE_POP_LO;
      cce_pkg::CCE_POP_LO: next_state = cce_pkg::CCE_FINISH;
      cce_pkg::CCE_FINISH: next_state = timer_done ? cce_pkg::CCE_IDLE : cce_pkg::CCE_FINISH;
      default: next_state = cce_pkg::CCE_IDLE;
    endcase
  end

  always_ff @(posedge CORE_CLK or posedge RESET) begin
    if (RESET) begin
      state <= cce_pkg::CCE_IDLE;
    end else begin
      state <= next_state;
    end
  end

  // Operand capture; the pair fetch reads the high destination byte then the low.
  always_ff @(posedge CORE_CLK or posedge RESET) begin
    if (RESET) begin
      kind <= cce_pkg::CCE_K_NONE;
      indirect <= 1'b0;
      target <= 8'h00;
      ret_addr <= 16'h0000;
      dest <= 16'h0000;
      sp <= 16'h0000;
      opnd <= 8'h00;
      pop_hi <= 8'h00;
    end else if (accept) begin
      kind <= (is_call_direct || is_call_pair) ? cce_pkg::CCE_K_CALL : is_carry ? cce_pkg::CCE_K_CARRY :
        is_zero ? cce_pkg::CCE_K_ZERO : is_invert ? cce_pkg::CCE_K_INVERT :
        is_exit ? cce_pkg::CCE_K_EXIT : cce_pkg::CCE_K_NONE;
      indirect <= 1'b0;
      target <= resolved;
      ret_addr <= NEXT_IP;
      dest <= DEST_ADDR;
      sp <= is_exit ? STACK_PTR_IN : sp_lowered;
    end else begin
      if (state == cce_pkg::CCE_FETCH_PTR) begin
        indirect <= 1'b1;
        if (kind == cce_pkg::CCE_K_CALL) begin
          if (!indirect) begin
            dest[15:8] <= REG_RDATA;
          end else begin
            dest[7:0] <= REG_RDATA;
          end
        end else begin
          target <= REG_RDATA;
        end
      end
      if (state == cce_pkg::CCE_READ_OPND) begin
        opnd <= inverted;
      end
      if (state == cce_pkg::CCE_POP_HI) begin
        pop_hi <= STK_RDATA;
      end
    end
  end

  wire fetch_rd = (state == cce_pkg::CCE_FETCH_PTR);
  wire [7:0] fetch_addr = (kind == cce_pkg::CCE_K_CALL) ? (indirect ? pair_base + 8'h01 : pair_base) : target;
  wire [7:0] inv_flags = {FLAGS_IN[`CCE_FLAG_C], (opnd == 8'h00), opnd[`CCE_SIGN_BIT], 1'b0,
    FLAGS_IN[3:0]};
  wire [7:0] carry_flags = FLAGS_IN ^ (8'h01 << `CCE_FLAG_C);

  assign BUSY = (state != cce_pkg::CCE_IDLE);
  assign DONE = (state == cce_pkg::CCE_FINISH) && timer_done;
  assign ILLEGAL = START && (state == cce_pkg::CCE_IDLE) && !known;
  assign REG_RD = fetch_rd || (state == cce_pkg::CCE_READ_OPND);
  assign REG_ADDR = fetch_rd ? fetch_addr : target;

  // Data-bearing outputs other than REG_ADDR are registered so a consumer samples stable values.
  always_ff @(posedge CORE_CLK or posedge RESET) begin
    if (RESET) begin
      REG_WR <= 1'b0;
      REG_WDATA <= 8'h00;
      STK_RD <= 1'b0;
      STK_WR <= 1'b0;
      STK_ADDR <= 16'h0000;
      STK_WDATA <= 8'h00;
      IP_LOAD <= 1'b0;
      IP_VALUE <= 16'h0000;
      SP_LOAD <= 1'b0;
      SP_VALUE <= 16'h0000;
      FLAGS_LOAD <= 1'b0;
      FLAGS_VALUE <= 8'h00;
    end else begin
      REG_WR <= (state == cce_pkg::CCE_WRITE_OPND);
      REG_WDATA <= (kind == cce_pkg::CCE_K_INVERT) ? opnd : 8'h00;
      STK_RD <= (next_state == cce_pkg::CCE_POP_HI) || (next_state == cce_pkg::CCE_POP_LO);
      STK_WR <= (state == cce_pkg::CCE_PUSH_HI) || (state == cce_pkg::CCE_PUSH_LO);
      STK_ADDR <= (next_state == cce_pkg::CCE_POP_LO || state == cce_pkg::CCE_PUSH_LO) ? sp + 16'h0001 :
        (state == cce_pkg::CCE_PUSH_HI) ? sp : STACK_PTR_IN;
      STK_WDATA <= (state == cce_pkg::CCE_PUSH_HI) ? ret_addr[15:8] : ret_addr[7:0];
      SP_LOAD <= (state == cce_pkg::CCE_PUSH_HI) || (state == cce_pkg::CCE_POP_LO);
      SP_VALUE <= (state == cce_pkg::CCE_POP_LO) ? sp + `CCE_SP_STEP : sp;
      IP_LOAD <= (state == cce_pkg::CCE_PUSH_LO) || (state == cce_pkg::CCE_POP_LO);
      IP_VALUE <= (state == cce_pkg::CCE_POP_LO) ? {pop_hi, STK_RDATA} : dest;
      FLAGS_LOAD <= ((state == cce_pkg::CCE_WRITE_OPND) && (kind == cce_pkg::CCE_K_INVERT)) ||
        (accept && is_carry);
      FLAGS_VALUE <= (state == cce_pkg::CCE_WRITE_OPND) ? inv_flags : carry_flags;
    end
  end
endmodule

/* File: testbench/call_clear_complement_exec_bench.sv */
// Self-checking bench for the execution unit.
module call_clear_complement_exec_bench;
  timeunit 1ns;
  timeprecision 100ps;
  logic CORE_CLK = 0, RESET = 1, START = 0;
  logic [7:0] OPCODE = 0, OPERAND = 0, FLAGS_IN = 0;
  logic [15:0] DEST_ADDR = 0, NEXT_IP = 0, STACK_PTR_IN = 0;
  logic [3:0] WORK_PTR = 0;
  logic BUSY, DONE, ILLEGAL, REG_RD, REG_WR, STK_RD, STK_WR, IP_LOAD, SP_LOAD, FLAGS_LOAD, fl_seen;
  logic [7:0] REG_ADDR, REG_WDATA, REG_RDATA, STK_WDATA, STK_RDATA, FLAGS_VALUE, fl_got;
  logic [15:0] STK_ADDR, IP_VALUE, SP_VALUE, ip_got, sp_got;
  int err_count = 0, n_checks = 0, cyc;
  cce_exec u_dut (.CORE_CLK(CORE_CLK), .RESET(RESET), .START(START), .OPCODE(OPCODE), .OPERAND(OPERAND),
    .DEST_ADDR(DEST_ADDR), .NEXT_IP(NEXT_IP), .STACK_PTR_IN(STACK_PTR_IN), .FLAGS_IN(FLAGS_IN),
    .WORK_PTR(WORK_PTR), .BUSY(BUSY), .DONE(DONE), .ILLEGAL(ILLEGAL), .REG_RD(REG_RD), .REG_WR(REG_WR),
    .REG_ADDR(REG_ADDR), .REG_WDATA(REG_WDATA), .REG_RDATA(REG_RDATA), .STK_RD(STK_RD), .STK_WR(STK_WR),
    .STK_ADDR(STK_ADDR), .STK_WDATA(STK_WDATA), .STK_RDATA(STK_RDATA), .IP_LOAD(IP_LOAD), .IP_VALUE(IP_VALUE),
    .SP_LOAD(SP_LOAD), .SP_VALUE(SP_VALUE), .FLAGS_LOAD(FLAGS_LOAD), .FLAGS_VALUE(FLAGS_VALUE));
  cce_partner u_part (.clk(CORE_CLK), .reg_rd(REG_RD), .reg_wr(REG_WR), .reg_addr(REG_ADDR),
    .reg_wdata(REG_WDATA), .reg_rdata(REG_RDATA), .stk_rd(STK_RD), .stk_wr(STK_WR),
    .stk_addr(STK_ADDR), .stk_wdata(STK_WDATA), .stk_rdata(STK_RDATA));
  initial forever #12.5 CORE_CLK = ~CORE_CLK;
  task automatic stop_test();
    $display("checks %0d mismatches %0d", n_checks, err_count);
    if (err_count == 0 && n_checks > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  // Counts one comparison and tells whether it held; an unknown counts as a failure.
  function automatic bit seen(input logic ok);
    n_checks++;
    return ok === 1'b1;
  endfunction
  task automatic miss(input string msg);
    err_count++;
    $display("MISMATCH at %0t: %s", $time, msg);
  endtask
  // Issues one instruction and records every load pulse until the last cycle.
  task automatic run(input logic [7:0] op, input logic [7:0] opnd, input int n);
    @(negedge CORE_CLK);
    OPCODE = op;
    OPERAND = opnd;
    START = 1;
    fl_seen = 0;
    @(negedge CORE_CLK);
    START = 0;
    cyc = 0;
    while (DONE !== 1'b1 && cyc < 40) begin
      if (IP_LOAD === 1'b1) ip_got = IP_VALUE;
      if (SP_LOAD === 1'b1) sp_got = SP_VALUE;
      if (FLAGS_LOAD === 1'b1) fl_got = FLAGS_VALUE;
      if (FLAGS_LOAD === 1'b1) fl_seen = 1;
      @(negedge CORE_CLK);
      cyc++;
    end
    if (cyc == 40) begin
      miss("timeout waiting for done");
      stop_test();
    end else begin
      if (!seen(cyc == n - 1)) miss("cycle count");
    end
  endtask
  task automatic t_call_exit();
    STACK_PTR_IN = 16'h3002;
    NEXT_IP = 16'h1A4A;
    DEST_ADDR = 16'h3521;
    FLAGS_IN = 8'hA5;
    run(8'hD6, 8'h00, 20);
    if (!seen(ip_got === 16'h3521 && sp_got === 16'h3000 && !fl_seen)) miss("direct call");
    if (!seen({u_part.stk[0], u_part.stk[1]} === 16'h1A4A)) miss("return address");
    STACK_PTR_IN = 16'h3000;
    run(8'hAF, 8'h00, 14);
    if (!seen(ip_got === 16'h1A4A && sp_got === 16'h3002)) miss("exit pop");
    u_part.regs[8'h14] = 8'h12;
    u_part.regs[8'h15] = 8'h34;
    WORK_PTR = 4'h1;
    STACK_PTR_IN = 16'h3002;
    run(8'hD4, 8'hE4, 20);
    if (!seen(ip_got === 16'h1234 && !fl_seen)) miss("pair call");
    $display("test call and exit done");
  endtask
  task automatic t_short();
    for (int i = 0; i < 2; i++) begin
      FLAGS_IN = i ? 8'h00 : 8'hFF;
      run(8'hEF, 8'h00, 6);
      if (!seen(fl_seen && fl_got === (i ? 8'h80 : 8'h7F))) miss("carry invert");
    end
    WORK_PTR = 4'h2;
    u_part.regs[8'h26] = 8'hAF;
    u_part.regs[8'h40] = 8'h27;
    u_part.regs[8'h27] = 8'h55;
    run(8'hB0, 8'hE6, 6);
    if (!seen(u_part.regs[8'h26] === 8'h00 && !fl_seen)) miss("zero fill register");
    run(8'hB1, 8'h40, 6);
    if (!seen(u_part.regs[8'h27] === 8'h00 && !fl_seen)) miss("zero fill indirect");
    u_part.regs[8'h28] = 8'h24;
    u_part.regs[8'h41] = 8'h29;
    u_part.regs[8'h29] = 8'hFF;
    FLAGS_IN = 8'h5F;
    run(8'h60, 8'hE8, 6);
    if (!seen(u_part.regs[8'h28] === 8'hDB && fl_got === 8'h2F)) miss("invert register");
    FLAGS_IN = 8'hAA;
    run(8'h61, 8'h41, 6);
    if (!seen(u_part.regs[8'h29] === 8'h00 && fl_got === 8'hCA)) miss("invert indirect");
    $display("test short instructions done");
  endtask
  task automatic t_unknown();
    @(negedge CORE_CLK);
    OPCODE = 8'h12;
    START = 1;
    #1;
    if (!seen(ILLEGAL === 1'b1)) miss("unknown opcode not flagged");
    @(negedge CORE_CLK);
    START = 0;
    if (!seen(BUSY === 1'b0)) miss("unknown opcode started");
    $display("test unknown opcode done");
  endtask
  initial begin
    repeat (12) @(negedge CORE_CLK);
    RESET = 0;
    t_call_exit();
    t_short();
    t_unknown();
    stop_test();
  end
endmodule

/* File: testbench/cce_exec_properties.sv */
// Concurrent checks on the execution unit's ports.
module cce_exec_properties (
  input wire logic CORE_CLK,
  input wire logic RESET,
  input wire logic START,
  input wire logic [7:0] OPCODE,
  input wire logic [7:0] OPERAND,
  input wire logic [15:0] NEXT_IP,
  input wire logic [15:0] STACK_PTR_IN,
  input wire logic [7:0] FLAGS_IN,
  input wire logic [3:0] WORK_PTR,
  input wire logic BUSY,
  input wire logic DONE,
  input wire logic REG_RD,
  input wire logic REG_WR,
  input wire logic [7:0] REG_ADDR,
  input wire logic [7:0] REG_WDATA,
  input wire logic STK_WR,
  input wire logic [15:0] STK_ADDR,
  input wire logic [7:0] STK_WDATA,
  input wire logic IP_LOAD,
  input wire logic SP_LOAD,
  input wire logic [15:0] SP_VALUE,
  input wire logic FLAGS_LOAD,
  input wire logic [7:0] FLAGS_VALUE
);
  timeunit 1ns;
  timeprecision 100ps;
  default clocking @(posedge CORE_CLK); endclocking
  default disable iff (RESET);
  wire take = START && !BUSY;
  wire is_call = OPCODE == 8'hD6 || OPCODE == 8'hD4;
  wire is_zero = OPCODE[7:1] == 7'h58;
  wire is_inv = OPCODE[7:1] == 7'h30;
  wire is_short = is_zero || is_inv || OPCODE == 8'hEF;
  a_call_twenty_cycles: assert property (take && is_call |-> ##20 DONE)
    else $error("call did not finish in its cycle count");
  a_short_six_cycles: assert property (take && is_short |-> ##1 (!DONE)[*5] ##1 DONE)
    else $error("short instruction did not finish in its cycle count");
  a_call_sp_step: assert property (take && is_call |-> ##[1:19] (SP_LOAD && SP_VALUE == STACK_PTR_IN - 16'h0002))
    else $error("stack pointer not lowered by two");
  a_push_pair_order: assert property (STK_WR && !$past(STK_WR) |-> STK_ADDR == STACK_PTR_IN - 16'h0002 &&
    STK_WDATA == NEXT_IP[15:8] ##1 STK_WR && STK_ADDR == STACK_PTR_IN - 16'h0001 && STK_WDATA == NEXT_IP[7:0])
    else $error("return address pushed wrongly");
  a_push_then_jump: assert property (STK_WR && $past(STK_WR) |-> IP_LOAD)
    else $error("pointer not loaded after the push");
  a_carry_invert: assert property (FLAGS_LOAD && OPCODE == 8'hEF |-> FLAGS_VALUE == (FLAGS_IN ^ 8'h80))
    else $error("carry invert changed wrong flags");
  a_invert_flags: assert property (FLAGS_LOAD && is_inv |-> REG_WR &&
    FLAGS_VALUE == {FLAGS_IN[7], REG_WDATA == 8'h00, REG_WDATA[7], 1'b0, FLAGS_IN[3:0]})
    else $error("invert flags wrong");
  a_zero_data: assert property (REG_WR && is_zero |-> REG_WDATA == 8'h00)
    else $error("zero fill wrote nonzero");
  a_flags_kept: assert property (BUSY && (is_call || is_zero) |-> !FLAGS_LOAD)
    else $error("flags loaded by call or zero fill");
  a_work_select: assert property (take && OPCODE == 8'h60 && OPERAND[7:4] == 4'hE |->
    ##[1:3] (REG_RD && REG_ADDR == {WORK_PTR, OPERAND[3:0]}))
    else $error("working register not selected");
endmodule
bind cce_exec cce_exec_properties u_props (.CORE_CLK(CORE_CLK), .RESET(RESET), .START(START), .OPCODE(OPCODE),
  .OPERAND(OPERAND), .NEXT_IP(NEXT_IP), .STACK_PTR_IN(STACK_PTR_IN), .FLAGS_IN(FLAGS_IN), .WORK_PTR(WORK_PTR),
  .BUSY(BUSY), .DONE(DONE), .REG_RD(REG_RD), .REG_WR(REG_WR), .REG_ADDR(REG_ADDR), .REG_WDATA(REG_WDATA),
  .STK_WR(STK_WR), .STK_ADDR(STK_ADDR), .STK_WDATA(STK_WDATA), .IP_LOAD(IP_LOAD), .SP_LOAD(SP_LOAD),
  .SP_VALUE(SP_VALUE), .FLAGS_LOAD(FLAGS_LOAD), .FLAGS_VALUE(FLAGS_VALUE));

/* File: testbench/cce_partner.sv */
// Behavioural register file and stack memory facing the execution unit.
module cce_partner (
  input wire logic clk,
  input wire logic reg_rd,
  input wire logic reg_wr,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  output logic [7:0] reg_rdata,
  input wire logic stk_rd,
  input wire logic stk_wr,
  input wire logic [15:0] stk_addr,
  input wire logic [7:0] stk_wdata,
  output logic [7:0] stk_rdata
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [7:0] regs [256];
  logic [7:0] stk [256];
  // Unselected reads return inverted data, so a read sampled outside its strobe is caught.
  assign reg_rdata = reg_rd ? regs[reg_addr] : ~regs[reg_addr];
  assign stk_rdata = stk_rd ? stk[stk_addr[7:0]] : ~stk[stk_addr[7:0]];
  always @(posedge clk) begin
    if (reg_wr) regs[reg_addr] <= reg_wdata;
    if (stk_wr) stk[stk_addr[7:0]] <= stk_wdata;
  end
endmodule
